// file: hw/pps_map.svh
// register offsets, field positions, reset values and limits of the program sequencer
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

`define PPS_ADDR_W        8
`define PPS_DATA_W        32
`define PPS_PC_W          8
`define PPS_GP_N          8
`define PPS_GP_SEL_W      3
`define PPS_GP_SAVE_N     4

`define PPS_OFF_GP0       8'h00
`define PPS_OFF_GP_LAST   8'h1c
`define PPS_OFF_CAPTURE   8'h20
`define PPS_OFF_PULSES    8'h24
`define PPS_OFF_STATUS    8'h28
`define PPS_OFF_CTRL      8'h2c

`define PPS_CTRL_START    0
`define PPS_CTRL_NV_SAVE  1
`define PPS_STAT_RUNNING  0
`define PPS_STAT_ARMED    1
`define PPS_STAT_WAITING  2

`define PPS_TRAVEL_MAX    32'sd999999
`define PPS_TRAVEL_MIN    -32'sd999999
`define PPS_SPEED_MAX     32'sd65535
`define PPS_TIME_MAX      32'sd65535
`define PPS_DWELL_MAX     32'sd65535
`define PPS_RERUN_MAX     32'sd65535

`define PPS_GP_RESET      32'h0000_0000
`define PPS_COUNT_ONE     32'h0000_0001

`endif

// file: hw/pps_pkg.sv
// types shared by the positioning program sequencer
package pps_pkg;

	typedef enum logic [3:0] {
		PPS_OP_STOP,
		PPS_OP_SPEED_SET,
		PPS_OP_ACCEL_TIME_SET,
		PPS_OP_DECEL_TIME_SET,
		PPS_OP_ACCEL_DECEL_TIME_SET,
		PPS_OP_EXTRA_TIME_CONSTANT_SET,
		PPS_OP_ABSOLUTE_TRAVEL,
		PPS_OP_INCREMENTAL_TRAVEL,
		PPS_OP_CONTINUOUS_ABSOLUTE_TRAVEL,
		PPS_OP_CONTINUOUS_INCREMENTAL_TRAVEL,
		PPS_OP_DWELL_STEP,
		PPS_OP_PROGRAM_RERUN,
		PPS_OP_PULSE_TALLY,
		PPS_OP_REPEAT_BEGIN,
		PPS_OP_REPEAT_END,
		PPS_OP_POSITION_CAPTURE_ARM
	} pps_op_type;

	typedef enum logic [2:0] {
		PPS_ST_IDLE,
		PPS_ST_EXEC,
		PPS_ST_MOTION,
		PPS_ST_TALLY,
		PPS_ST_CAPTURE
	} pps_state_type;

endpackage : pps_pkg

// file: hw/pps_sequencer.sv
// step sequencer for a stored positioning program, with register port
//
// What this block does
// - tally wait advances once total exceeds value
// - zero tally step clears pulse total
// - repeat block runs n times, zero endless
// - rerun only as first step, else once
// - whole program reruns n times, zero endless
// - capture arm holds until trigger switches on
// - trigger stores position, host reads it
// - captured position kept until power off
// - trigger, end, mode, stop, alarm, servo-off disarm
// - temporary stop keeps capture armed
// - operands may come from eight registers
// - registers volatile, first four saveable
// - register operand limited to step range
`include "pps_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pps_sequencer
	import pps_pkg::*;
(
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire logic [`PPS_ADDR_W-1:0]   i_addr,
	input  wire logic [`PPS_DATA_W-1:0]   i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [`PPS_DATA_W-1:0]   o_rdata,
	output logic      [`PPS_PC_W-1:0]     o_step_addr,
	input  wire pps_op_type               i_step_op,
	input  wire logic                     i_step_use_reg,
	input  wire logic [`PPS_GP_SEL_W-1:0] i_step_reg_sel,
	input  wire logic [`PPS_DATA_W-1:0]   i_step_value,
	output logic                          o_cmd_valid,
	output pps_op_type                    o_cmd_op,
	output logic      [`PPS_DATA_W-1:0]   o_cmd_value,
	input  wire logic                     i_cmd_done,
	input  wire logic                     i_mpg_pulse,
	input  wire logic                     i_capture_trigger_input,
	input  wire logic [`PPS_DATA_W-1:0]   i_cur_pos,
	input  wire logic                     i_temp_stop,
	input  wire logic                     i_mode_change,
	input  wire logic                     i_forced_stop,
	input  wire logic                     i_alarm,
	input  wire logic                     i_servo_off,
	output logic                          o_running,
	output logic                          o_capture_armed,
	output logic                          o_program_end,
	output logic                          o_nv_save,
	output logic [`PPS_GP_SAVE_N*`PPS_DATA_W-1:0] o_nv_data
);

	function automatic logic is_motion(input pps_op_type op);
		unique case (op)
			PPS_OP_SPEED_SET, PPS_OP_ACCEL_TIME_SET, PPS_OP_DECEL_TIME_SET,
			PPS_OP_ACCEL_DECEL_TIME_SET, PPS_OP_EXTRA_TIME_CONSTANT_SET,
			PPS_OP_ABSOLUTE_TRAVEL, PPS_OP_INCREMENTAL_TRAVEL,
			PPS_OP_CONTINUOUS_ABSOLUTE_TRAVEL, PPS_OP_CONTINUOUS_INCREMENTAL_TRAVEL,
			PPS_OP_DWELL_STEP: is_motion = 1'b1;
			default:           is_motion = 1'b0;
		endcase
	endfunction : is_motion

	function automatic logic is_travel(input pps_op_type op);
		is_travel = (op == PPS_OP_ABSOLUTE_TRAVEL) || (op == PPS_OP_INCREMENTAL_TRAVEL) ||
			(op == PPS_OP_CONTINUOUS_ABSOLUTE_TRAVEL) ||
			(op == PPS_OP_CONTINUOUS_INCREMENTAL_TRAVEL);
	endfunction : is_travel

	// limit an operand to the legal range of the step that uses it
	function automatic logic [`PPS_DATA_W-1:0] clamp_operand(input pps_op_type op,
			input logic [`PPS_DATA_W-1:0] raw);
		logic signed [`PPS_DATA_W-1:0] v;
		logic signed [`PPS_DATA_W-1:0] hi;
		logic signed [`PPS_DATA_W-1:0] lo;
		v  = signed'(raw);
		lo = 32'sd0;
		unique case (op)
			PPS_OP_SPEED_SET:   hi = `PPS_SPEED_MAX;
			PPS_OP_DWELL_STEP:  hi = `PPS_DWELL_MAX;
			PPS_OP_PROGRAM_RERUN: hi = `PPS_RERUN_MAX;
			default:            hi = `PPS_TIME_MAX;
		endcase
		if (is_travel(op)) begin
			hi = `PPS_TRAVEL_MAX;
			lo = `PPS_TRAVEL_MIN;
		end
		if (v > hi)
			clamp_operand = hi;
		else if (v < lo)
			clamp_operand = lo;
		else
			clamp_operand = raw;
	endfunction : clamp_operand

	function automatic logic is_gp_addr(input logic [`PPS_ADDR_W-1:0] a);
		is_gp_addr = (a <= `PPS_OFF_GP_LAST) && (a[1:0] == 2'b00);
	endfunction : is_gp_addr

	pps_state_type                           st_r, st_nxt;
	logic [`PPS_PC_W-1:0]                    pc_r, pc_nxt;
	logic [`PPS_PC_W-1:0]                    restart_r, restart_nxt;
	logic [`PPS_PC_W-1:0]                    loop_start_r, loop_start_nxt;
	logic [`PPS_DATA_W-1:0]                  loop_left_r, loop_left_nxt;
	logic                                    loop_inf_r, loop_inf_nxt;
	logic [`PPS_DATA_W-1:0]                  rerun_left_r, rerun_left_nxt;
	logic                                    rerun_inf_r, rerun_inf_nxt;
	logic [`PPS_DATA_W-1:0]                  target_r, target_nxt;
	logic [`PPS_DATA_W-1:0]                  pulse_total_r, pulse_total_nxt;
	logic [`PPS_DATA_W-1:0]                  captured_r, captured_nxt;
	logic                                    armed_r, armed_nxt;
	logic                                    trig_prev_r;
	logic                                    cmd_valid_r, cmd_valid_nxt;
	pps_op_type                              cmd_op_r, cmd_op_nxt;
	logic [`PPS_DATA_W-1:0]                  cmd_value_r, cmd_value_nxt;
	logic                                    end_r, end_nxt;
	logic                                    running_r, running_nxt;
	logic [`PPS_GP_N-1:0][`PPS_DATA_W-1:0]   gp_r, gp_nxt;
	logic [`PPS_DATA_W-1:0]                  rdata_r, rdata_nxt;
	logic                                    nv_save_r, nv_save_nxt;

	logic                                    abort_w;
	logic                                    trig_rise_w;
	logic                                    start_w;
	logic                                    step_go_w;
	logic [`PPS_DATA_W-1:0]                  operand_w;

	assign abort_w     = i_mode_change | i_forced_stop | i_alarm | i_servo_off;
	assign trig_rise_w = i_capture_trigger_input & ~trig_prev_r;
	assign start_w     = i_wr && (i_addr == `PPS_OFF_CTRL) && i_wdata[`PPS_CTRL_START];
	// a temporary stop only freezes stepping; it touches no other state
	assign step_go_w   = (st_r == PPS_ST_EXEC) && !i_temp_stop && !abort_w;
	assign operand_w   = clamp_operand(i_step_op,
		i_step_use_reg ? gp_r[i_step_reg_sel] : i_step_value);

	always_comb begin
		st_nxt          = st_r;
		pc_nxt          = pc_r;
		restart_nxt     = restart_r;
		loop_start_nxt  = loop_start_r;
		loop_left_nxt   = loop_left_r;
		loop_inf_nxt    = loop_inf_r;
		rerun_left_nxt  = rerun_left_r;
		rerun_inf_nxt   = rerun_inf_r;
		target_nxt      = target_r;
		pulse_total_nxt = pulse_total_r + {{(`PPS_DATA_W-1){1'b0}}, i_mpg_pulse};
		captured_nxt    = captured_r;
		armed_nxt       = armed_r;
		cmd_valid_nxt   = 1'b0;
		cmd_op_nxt      = cmd_op_r;
		cmd_value_nxt   = cmd_value_r;
		end_nxt         = 1'b0;
		if (armed_r && trig_rise_w) begin
			captured_nxt = i_cur_pos;
			armed_nxt    = 1'b0;
		end
		unique case (st_r)
			PPS_ST_IDLE: begin
				if (start_w && !abort_w) begin
					st_nxt         = PPS_ST_EXEC;
					pc_nxt         = '0;
					restart_nxt    = '0;
					rerun_left_nxt = `PPS_COUNT_ONE;
					rerun_inf_nxt  = 1'b0;
					loop_inf_nxt   = 1'b0;
				end
			end
			PPS_ST_EXEC: begin
				if (step_go_w) begin
					pc_nxt = pc_r + 1'b1;
					unique case (i_step_op)
						PPS_OP_STOP: begin
							if (rerun_inf_r || (rerun_left_r > `PPS_COUNT_ONE)) begin
								rerun_left_nxt = rerun_left_r - 1'b1;
								pc_nxt         = restart_r;
								loop_inf_nxt   = 1'b0;
							end else begin
								st_nxt    = PPS_ST_IDLE;
								pc_nxt    = pc_r;
								end_nxt   = 1'b1;
								armed_nxt = 1'b0;
							end
						end
						PPS_OP_PROGRAM_RERUN: begin
							// honoured only as the first step; elsewhere it is skipped
							if (pc_r == '0) begin
								rerun_left_nxt = operand_w;
								rerun_inf_nxt  = (operand_w == '0);
								restart_nxt    = 8'h01;
							end
						end
						PPS_OP_PULSE_TALLY: begin
							if (operand_w == '0) begin
								pulse_total_nxt = '0;
							end else begin
								target_nxt = operand_w;
								st_nxt     = PPS_ST_TALLY;
								pc_nxt     = pc_r;
							end
						end
						PPS_OP_REPEAT_BEGIN: begin
							// one loop context only, so nested blocks are not supported
							loop_start_nxt = pc_r + 1'b1;
							loop_left_nxt  = operand_w;
							loop_inf_nxt   = (operand_w == '0);
						end
						PPS_OP_REPEAT_END: begin
							if (loop_inf_r || (loop_left_r > `PPS_COUNT_ONE)) begin
								loop_left_nxt = loop_left_r - 1'b1;
								pc_nxt        = loop_start_r;
							end
						end
						PPS_OP_POSITION_CAPTURE_ARM: begin
							armed_nxt = 1'b1;
							st_nxt    = PPS_ST_CAPTURE;
							pc_nxt    = pc_r;
						end
						default: begin
							cmd_valid_nxt = is_motion(i_step_op);
							cmd_op_nxt    = i_step_op;
							cmd_value_nxt = operand_w;
							st_nxt        = PPS_ST_MOTION;
							pc_nxt        = pc_r;
						end
					endcase
				end
			end
			PPS_ST_MOTION: begin
				if (i_cmd_done) begin
					st_nxt = PPS_ST_EXEC;
					pc_nxt = pc_r + 1'b1;
				end
			end
			PPS_ST_TALLY: begin
				if (pulse_total_r > target_r) begin
					st_nxt = PPS_ST_EXEC;
					pc_nxt = pc_r + 1'b1;
				end
			end
			PPS_ST_CAPTURE: begin
				if (trig_rise_w) begin
					st_nxt = PPS_ST_EXEC;
					pc_nxt = pc_r + 1'b1;
				end
			end
		endcase
		if (abort_w) begin
			armed_nxt = 1'b0;
			if (st_r != PPS_ST_IDLE) begin
				st_nxt  = PPS_ST_IDLE;
				end_nxt = 1'b1;
			end
		end
		// registered copy so the running output comes straight from a flop
		running_nxt = (st_nxt != PPS_ST_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r          <= PPS_ST_IDLE;
			pc_r          <= '0;
			restart_r     <= '0;
			loop_start_r  <= '0;
			loop_left_r   <= '0;
			loop_inf_r    <= 1'b0;
			rerun_left_r  <= '0;
			rerun_inf_r   <= 1'b0;
			target_r      <= '0;
			pulse_total_r <= '0;
			captured_r    <= '0;
			armed_r       <= 1'b0;
			trig_prev_r   <= 1'b0;
			cmd_valid_r   <= 1'b0;
			cmd_op_r      <= PPS_OP_STOP;
			cmd_value_r   <= '0;
			end_r         <= 1'b0;
			running_r     <= 1'b0;
		end else begin
			st_r          <= st_nxt;
			pc_r          <= pc_nxt;
			restart_r     <= restart_nxt;
			loop_start_r  <= loop_start_nxt;
			loop_left_r   <= loop_left_nxt;
			loop_inf_r    <= loop_inf_nxt;
			rerun_left_r  <= rerun_left_nxt;
			rerun_inf_r   <= rerun_inf_nxt;
			target_r      <= target_nxt;
			pulse_total_r <= pulse_total_nxt;
			captured_r    <= captured_nxt;
			armed_r       <= armed_nxt;
			trig_prev_r   <= i_capture_trigger_input;
			cmd_valid_r   <= cmd_valid_nxt;
			cmd_op_r      <= cmd_op_nxt;
			cmd_value_r   <= cmd_value_nxt;
			end_r         <= end_nxt;
			running_r     <= running_nxt;
		end
	end

	// register port; reset stands in for power-up, so the registers start empty
	always_comb begin
		gp_nxt      = gp_r;
		rdata_nxt   = '0;
		nv_save_nxt = i_wr && (i_addr == `PPS_OFF_CTRL) && i_wdata[`PPS_CTRL_NV_SAVE];
		if (i_wr && is_gp_addr(i_addr) && (st_r == PPS_ST_IDLE))
			gp_nxt[i_addr[4:2]] = i_wdata;
		if (i_rd) begin
			if (is_gp_addr(i_addr))
				rdata_nxt = gp_r[i_addr[4:2]];
			else if (i_addr == `PPS_OFF_CAPTURE)
				rdata_nxt = captured_r;
			else if (i_addr == `PPS_OFF_PULSES)
				rdata_nxt = pulse_total_r;
			else if (i_addr == `PPS_OFF_STATUS) begin
				rdata_nxt[`PPS_STAT_RUNNING] = (st_r != PPS_ST_IDLE);
				rdata_nxt[`PPS_STAT_ARMED]   = armed_r;
				rdata_nxt[`PPS_STAT_WAITING] = (st_r == PPS_ST_TALLY) || (st_r == PPS_ST_CAPTURE);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gp_r      <= '0;
			rdata_r   <= '0;
			nv_save_r <= 1'b0;
		end else begin
			gp_r      <= gp_nxt;
			rdata_r   <= rdata_nxt;
			nv_save_r <= nv_save_nxt;
		end
	end

	assign o_rdata         = rdata_r;
	assign o_step_addr     = pc_r;
	assign o_cmd_valid     = cmd_valid_r;
	assign o_cmd_op        = cmd_op_r;
	assign o_cmd_value     = cmd_value_r;
	assign o_running       = running_r;
	assign o_capture_armed = armed_r;
	assign o_program_end   = end_r;
	assign o_nv_save       = nv_save_r;
	assign o_nv_data       = {gp_r[3], gp_r[2], gp_r[1], gp_r[0]};

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence cap_fire_s;
		armed_r && trig_rise_w;
	endsequence

	sequence cap_wait_s;
		(st_r == PPS_ST_CAPTURE) && !trig_rise_w && !abort_w;
	endsequence

	tally_advance_a: assert property ((st_r == PPS_ST_TALLY) && (pulse_total_r > target_r) && !abort_w
		|=> (st_r == PPS_ST_EXEC) && (pc_r == $past(pc_r) + 8'h01))
		else $error("tally wait did not advance");
	tally_hold_a: assert property ((st_r == PPS_ST_TALLY) && (pulse_total_r <= target_r) && !abort_w
		|=> (st_r == PPS_ST_TALLY))
		else $error("tally wait left early");
	tally_clear_a: assert property (step_go_w && (i_step_op == PPS_OP_PULSE_TALLY) && (operand_w == '0)
		|=> (pulse_total_r == '0) && (st_r == PPS_ST_EXEC))
		else $error("zero tally did not clear total");
	loop_back_a: assert property (step_go_w && (i_step_op == PPS_OP_REPEAT_END) && loop_inf_r
		|=> pc_r == $past(loop_start_r))
		else $error("endless repeat did not jump back");
	rerun_skip_a: assert property (step_go_w && (i_step_op == PPS_OP_PROGRAM_RERUN) && (pc_r != '0)
		|=> $stable(rerun_left_r) && $stable(restart_r))
		else $error("rerun step honoured past first step");
	program_end_a: assert property (step_go_w && (i_step_op == PPS_OP_STOP) && !rerun_inf_r
		&& (rerun_left_r <= `PPS_COUNT_ONE) |=> (st_r == PPS_ST_IDLE) && o_program_end && !armed_r)
		else $error("last pass did not end program");
	capture_hold_a: assert property (cap_wait_s |=> (st_r == PPS_ST_CAPTURE) [*1] ##0 armed_r
		|| abort_w)
		else $error("capture step advanced without trigger");
	capture_store_a: assert property (cap_fire_s |=> (captured_r == $past(i_cur_pos)) && !armed_r)
		else $error("capture did not store position");
	capture_keep_a: assert property (!(armed_r && trig_rise_w) |=> $stable(captured_r))
		else $error("captured position changed");
	abort_disarm_a: assert property (abort_w |=> !armed_r && (st_r == PPS_ST_IDLE))
		else $error("abort left capture armed");
	pause_armed_a: assert property (armed_r && i_temp_stop && !abort_w && !trig_rise_w
		|=> armed_r)
		else $error("temporary stop disarmed capture");
	operand_pick_a: assert property (step_go_w && is_motion(i_step_op)
		|=> o_cmd_valid && (o_cmd_value == $past(operand_w)))
		else $error("issued operand wrong");
	gp_locked_a: assert property (i_wr && (st_r != PPS_ST_IDLE) |=> $stable(gp_r))
		else $error("register changed while running");
	travel_range_a: assert property (o_cmd_valid && is_travel(o_cmd_op)
		|-> (signed'(o_cmd_value) <= `PPS_TRAVEL_MAX)
		&& (signed'(o_cmd_value) >= `PPS_TRAVEL_MIN))
		else $error("travel operand out of range");

endmodule : pps_sequencer

`default_nettype wire

// file: test/pps_far_model.sv
// far-side model: program store plus a motion axis that answers issued steps
`include "pps_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pps_far_model
	import pps_pkg::*;
(
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire logic [`PPS_PC_W-1:0]     i_step_addr,
	input  wire logic                     i_cmd_valid,
	input  wire logic [3:0]               i_lag,
	output pps_op_type                    o_step_op,
	output logic                          o_step_use_reg,
	output logic      [`PPS_GP_SEL_W-1:0] o_step_reg_sel,
	output logic      [`PPS_DATA_W-1:0]   o_step_value,
	output logic                          o_cmd_done
);
	pps_op_type                 op_mem  [256];
	logic                       ur_mem  [256];
	logic [`PPS_GP_SEL_W-1:0]   sel_mem [256];
	logic [`PPS_DATA_W-1:0]     val_mem [256];
	logic                       busy_r;
	logic [3:0]                 cnt_r;

	task automatic wipe();
		for (int i = 0; i < 256; i++) begin
			op_mem[i] = PPS_OP_STOP;
			ur_mem[i] = 1'b0;
			sel_mem[i] = '0;
			val_mem[i] = '0;
		end
	endtask : wipe

	task automatic put(input int i, input pps_op_type op, input logic ur,
			input logic [2:0] sel, input logic [31:0] val);
		op_mem[i] = op;
		ur_mem[i] = ur;
		sel_mem[i] = sel;
		val_mem[i] = val;
	endtask : put

	initial wipe();

	// store answers in the same cycle as the step index
	assign o_step_op      = op_mem[i_step_addr];
	assign o_step_use_reg = ur_mem[i_step_addr];
	assign o_step_reg_sel = sel_mem[i_step_addr];
	assign o_step_value   = val_mem[i_step_addr];

	// the axis finishes i_lag+1 cycles after it sees an issue, so prompt and slow answers both occur
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
			o_cmd_done <= 1'b0;
		end else begin
			o_cmd_done <= 1'b0;
			if (i_cmd_valid) begin
				busy_r <= 1'b1;
				cnt_r <= i_lag;
			end else if (busy_r && cnt_r == 4'h0) begin
				busy_r <= 1'b0;
				o_cmd_done <= 1'b1;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end

endmodule : pps_far_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench of the program sequencer: registers, steps, tally, capture, aborts
`include "pps_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb
	import pps_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0]  step_addr;
	pps_op_type  step_op;
	logic        use_reg;
	logic [2:0]  reg_sel;
	logic [31:0] step_val;
	logic        cmd_valid;
	pps_op_type  cmd_op;
	logic [31:0] cmd_val;
	logic        cmd_done;
	logic        mpg = 1'b0;
	logic        trig = 1'b0;
	logic [31:0] cur_pos = 32'h0;
	logic        tstop = 1'b0;
	logic [3:0]  abort = 4'h0;
	logic [3:0]  lag = 4'h0;
	logic        running;
	logic        armed;
	logic        prog_end;
	logic        nv_save;
	logic [127:0] nv_data;
	logic [31:0] q [$];
	logic [31:0] v;
	logic [31:0] ea [4];
	int          n_fail = 0;
	int          total_checks = 0;
	int          n_end = 0;

	pps_sequencer pps_sequencer_i (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_step_addr(step_addr),
		.i_step_op(step_op), .i_step_use_reg(use_reg), .i_step_reg_sel(reg_sel),
		.i_step_value(step_val), .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op),
		.o_cmd_value(cmd_val), .i_cmd_done(cmd_done), .i_mpg_pulse(mpg),
		.i_capture_trigger_input(trig), .i_cur_pos(cur_pos), .i_temp_stop(tstop),
		.i_mode_change(abort[0]), .i_forced_stop(abort[1]), .i_alarm(abort[2]),
		.i_servo_off(abort[3]), .o_running(running), .o_capture_armed(armed),
		.o_program_end(prog_end), .o_nv_save(nv_save), .o_nv_data(nv_data));

	pps_far_model pps_far_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_step_addr(step_addr),
		.i_cmd_valid(cmd_valid), .i_lag(lag), .o_step_op(step_op), .o_step_use_reg(use_reg),
		.o_step_reg_sel(reg_sel), .o_step_value(step_val), .o_cmd_done(cmd_done));

	always #10 clk = ~clk;

	always @(posedge clk) begin
		if (cmd_valid === 1'b1) begin
			q.push_back(cmd_val);
		end
		if (prog_end === 1'b1) begin
			n_end++;
		end
	end

	task automatic wrap_up();
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic pulses(input int n);
		@(posedge clk) mpg <= 1'b1;
		repeat (n) @(posedge clk);
		mpg <= 1'b0;
	endtask : pulses

	task automatic st(input int i, input pps_op_type op, input logic ur,
			input logic [2:0] sel, input logic [31:0] val);
		pps_far_model_i.put(i, op, ur, sel, val);
	endtask : st

	task automatic start();
		q.delete();
		wr_reg(`PPS_OFF_CTRL, 32'h1);
	endtask : start

	task automatic wait_idle();
		int n;
		n = 0;
		#1;
		while (running !== 1'b0 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000) begin
			n_fail++;
			$display("[ERR] idle expected 1 seen 0");
		end
	endtask : wait_idle

	initial begin
		#1_000_000;
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int n = 0; n < 8; n++) begin
			rd_reg(8'(4 * n), v);
			chk("gp reset", v, 32'h0);
		end
		rd_reg(`PPS_OFF_CAPTURE, v);
		chk("capture reset", v, 32'h0);
		rd_reg(`PPS_OFF_STATUS, v);
		chk("status reset", v, 32'h0);
		rd_reg(8'h40, v);
		chk("unmapped", v, 32'h0);
		// registers are only touched while idle
		for (int n = 0; n < 8; n++) wr_reg(8'(4 * n), 32'h100 + n);
		for (int n = 0; n < 8; n++) begin
			rd_reg(8'(4 * n), v);
			chk("gp readback", v, 32'h100 + n);
		end
		wr_reg(`PPS_OFF_CTRL, 32'h2);
		#1;
		chk("nv pulse", {31'h0, nv_save}, 32'h1);
		chk("nv word3", nv_data[127:96], 32'h103);
		wr_reg(8'h00, 32'h3e8);
		wr_reg(8'h1c, 32'h11170);
		// rerun first, register operands, clamped values
		pps_far_model_i.wipe();
		st(0, PPS_OP_PROGRAM_RERUN, 1'b0, 3'h0, 32'h2);
		st(1, PPS_OP_SPEED_SET, 1'b1, 3'h7, 32'h0);
		st(2, PPS_OP_INCREMENTAL_TRAVEL, 1'b1, 3'h0, 32'h0);
		st(3, PPS_OP_ABSOLUTE_TRAVEL, 1'b0, 3'h0, 32'd2000000);
		st(4, PPS_OP_DWELL_STEP, 1'b0, 3'h0, 32'h64);
		ea = '{32'hffff, 32'h3e8, 32'hf423f, 32'h64};
		lag <= 4'h6;
		start();
		wr_reg(8'h00, 32'h5);
		wait_idle();
		chk("rerun count", q.size(), 32'h8);
		for (int i = 0; i < 8; i++) chk("operand", q[i], ea[i % 4]);
		chk("last op", {28'h0, cmd_op}, 32'ha);
		rd_reg(8'h00, v);
		chk("gp busy write", v, 32'h3e8);
		// loop of three, rerun step out of place is skipped
		pps_far_model_i.wipe();
		st(0, PPS_OP_DWELL_STEP, 1'b0, 3'h0, 32'h1);
		st(1, PPS_OP_REPEAT_BEGIN, 1'b0, 3'h0, 32'h3);
		st(2, PPS_OP_DWELL_STEP, 1'b0, 3'h0, 32'h7);
		st(3, PPS_OP_REPEAT_END, 1'b0, 3'h0, 32'h0);
		st(4, PPS_OP_PROGRAM_RERUN, 1'b0, 3'h0, 32'h5);
		lag <= 4'h0;
		start();
		wait_idle();
		chk("loop count", q.size(), 32'h4);
		chk("loop last", q[3], 32'h7);
		// pulse tally
		pps_far_model_i.wipe();
		st(0, PPS_OP_PULSE_TALLY, 1'b0, 3'h0, 32'h0);
		st(1, PPS_OP_PULSE_TALLY, 1'b0, 3'h0, 32'h3);
		st(2, PPS_OP_DWELL_STEP, 1'b0, 3'h0, 32'h9);
		pulses(4);
		rd_reg(`PPS_OFF_PULSES, v);
		chk("idle tally", v, 32'h4);
		start();
		tick(5);
		rd_reg(`PPS_OFF_PULSES, v);
		chk("tally cleared", v, 32'h0);
		rd_reg(`PPS_OFF_STATUS, v);
		chk("tally status", v, 32'h5);
		pulses(3);
		tick(3);
		chk("tally equal", {24'h0, step_addr}, 32'h1);
		pulses(1);
		wait_idle();
		chk("tally passed", q.size(), 32'h1);
		rd_reg(`PPS_OFF_PULSES, v);
		chk("tally kept", v, 32'h4);
		// capture: level already high is no edge; temporary stop keeps it armed
		pps_far_model_i.wipe();
		st(0, PPS_OP_POSITION_CAPTURE_ARM, 1'b0, 3'h0, 32'h0);
		@(posedge clk) trig <= 1'b1;
		cur_pos <= 32'h4d2;
		start();
		tick(4);
		rd_reg(`PPS_OFF_STATUS, v);
		chk("armed status", v, 32'h7);
		@(posedge clk) tstop <= 1'b1;
		tick(3);
		chk("temp stop", {31'h0, armed}, 32'h1);
		@(posedge clk) tstop <= 1'b0;
		trig <= 1'b0;
		@(posedge clk) trig <= 1'b1;
		wait_idle();
		chk("disarm edge", {31'h0, armed}, 32'h0);
		rd_reg(`PPS_OFF_CAPTURE, v);
		chk("captured", v, 32'h4d2);
		@(posedge clk) trig <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			cur_pos <= 32'h99 + k;
			start();
			tick(3);
			chk("armed", {31'h0, armed}, 32'h1);
			@(posedge clk) abort[k] <= 1'b1;
			@(posedge clk) abort[k] <= 1'b0;
			tick(2);
			chk("abort disarm", {30'h0, running, armed}, 32'h0);
			rd_reg(`PPS_OFF_CAPTURE, v);
			chk("capture kept", v, 32'h4d2);
		end
		// endless loop, then endless rerun, both cut by a forced stop
		for (int p = 0; p < 2; p++) begin
			pps_far_model_i.wipe();
			if (p == 0) begin
				st(0, PPS_OP_REPEAT_BEGIN, 1'b0, 3'h0, 32'h0);
				st(1, PPS_OP_DWELL_STEP, 1'b0, 3'h0, 32'h1);
				st(2, PPS_OP_REPEAT_END, 1'b0, 3'h0, 32'h0);
			end else begin
				st(0, PPS_OP_PROGRAM_RERUN, 1'b0, 3'h0, 32'h0);
				st(1, PPS_OP_DWELL_STEP, 1'b0, 3'h0, 32'h2);
			end
			start();
			tick(300);
			chk("endless run", {31'h0, running}, 32'h1);
			chk("endless steps", {31'h0, q.size() > 20}, 32'h1);
			@(posedge clk) abort[1] <= 1'b1;
			@(posedge clk) abort[1] <= 1'b0;
			tick(2);
			chk("forced stop", {31'h0, running}, 32'h0);
		end
		chk("end pulses", n_end, 32'd10);
		wrap_up();
	end

endmodule : tb
`default_nettype wire
